//--- common/acsw_pkg.sv
// Constants for the converter control, sample time and watchdog block.
// Assumes an APB slave on pclk, 32-bit data, word aligned registers.
package acsw_pkg;

  // Register byte offsets
  localparam logic [7:0] ACSW_OFF_CTRL3 = 8'h0C;
  localparam logic [7:0] ACSW_OFF_SAMP  = 8'h10;
  localparam logic [7:0] ACSW_OFF_HIGH  = 8'h14;
  localparam logic [7:0] ACSW_OFF_LOW   = 8'h18;
  localparam logic [7:0] ACSW_OFF_STAT  = 8'h30;
  localparam logic [7:0] ACSW_OFF_MASK  = 8'h34;

  // Control three field positions
  localparam int ACSW_B_DONE_IEN = 5;
  localparam int ACSW_B_PDOWN    = 4;
  localparam int ACSW_B_RDY      = 3;
  localparam int ACSW_B_REF_RDY  = 2;
  localparam int ACSW_B_REF_EN   = 1;

  // Event status bit positions
  localparam int ACSW_EV_DONE = 0;
  localparam int ACSW_EV_WDG  = 1;
  localparam int ACSW_EV_W    = 2;

  // Field widths and reset values
  localparam int ACSW_CODE_W = 5;
  localparam int ACSW_LIM_W  = 12;
  localparam int ACSW_CNT_W  = 12;
  localparam logic [4:0]  ACSW_SAMP_RST = 5'h02;
  localparam logic [11:0] ACSW_HIGH_RST = 12'hFFF;
  localparam logic [11:0] ACSW_LOW_RST  = 12'h000;
  localparam logic [1:0]  ACSW_MASK_RST = 2'h3;
  localparam logic [4:0]  ACSW_CODE_MAX = 5'h11;

  // Sample cycles per code; code zero is reserved and yields zero
  localparam logic [11:0] ACSW_SAMP_TAB [0:17] = '{
    12'h000, 12'h008, 12'h00C, 12'h00E, 12'h014, 12'h01A,
    12'h01E, 12'h02A, 12'h038, 12'h048, 12'h058, 12'h078,
    12'h0B6, 12'h0F0, 12'h17C, 12'h2F8, 12'h5F0, 12'hBE0};

endpackage : acsw_pkg

//--- rtl/acsw_sample_timer.sv
// Sample-phase timer: counts the cycles chosen by the sample time code.
// Assumes start pulses come from the conversion core on pclk.
module acsw_sample_timer
  import acsw_pkg::*;
(
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // Control
  input  wire logic [ACSW_CODE_W-1:0] code,
  input  wire logic                   start,
  // Status
  output logic                        sampling_r,
  output logic                        sample_done_r
);

  logic [ACSW_CNT_W-1:0] cnt_r;
  logic [ACSW_CNT_W-1:0] len;

  // Reserved or out-of-range codes give zero length and never start
  always_comb begin
    len = (code > ACSW_CODE_MAX) ? '0 : ACSW_SAMP_TAB[code];
  end

  // Length latched at start so a later code write cannot stretch it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r         <= '0;
      sampling_r    <= 1'b0;
      sample_done_r <= 1'b0;
    end else begin
      sample_done_r <= 1'b0;
      if (sampling_r) begin
        cnt_r <= cnt_r - 12'h001;
        if (cnt_r == 12'h001) begin
          sampling_r    <= 1'b0;
          sample_done_r <= 1'b1;
        end
      end else if (start && len != '0) begin
        cnt_r      <= len;
        sampling_r <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence samp_go_s;
    !sampling_r && start && len != '0;
  endsequence

  samp_load_a: assert property (samp_go_s |=> sampling_r && cnt_r == $past(len))
    else $error("sample length not loaded from code");
  samp_end_a: assert property (sampling_r && cnt_r == 12'h001 |=> sample_done_r && !sampling_r)
    else $error("sample phase did not end on count");
  samp_rsvd_a: assert property (!sampling_r && start && code == 5'h00 |=> !sampling_r)
    else $error("reserved code started sampling");

endmodule : acsw_sample_timer

//--- rtl/acsw_top.sv
// Converter control three, sample time and watchdog limit registers.
// Assumes an APB master on pclk and a conversion core giving status levels.
module acsw_top
  import acsw_pkg::*;
(
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // Conversion core status
  input  wire logic                  core_powered_down,
  input  wire logic                  core_ready,
  input  wire logic                  int_reference_ready,
  input  wire logic                  any_channel_done_flag,
  input  wire logic [ACSW_LIM_W-1:0] conv_data,
  input  wire logic                  sample_start,
  // Conversion core control
  output logic                       int_reference_enable,
  output logic                       sampling,
  output logic                       sample_done,
  // Interrupt
  output logic                       irq
);

  // Register state
  logic                   done_ien_r;
  logic                   ref_en_r;
  logic [ACSW_CODE_W-1:0] samp_code_r;
  logic [ACSW_LIM_W-1:0]  watch_high_limit_r;
  logic [ACSW_LIM_W-1:0]  watch_low_limit_r;
  logic [ACSW_EV_W-1:0]   stat_r;
  logic [ACSW_EV_W-1:0]   mask_r;
  logic                   pready_r;
  logic [31:0]            prdata_r;
  logic                   pslverr_r;
  logic                   irq_r;

  // Bus decode
  logic                   setup;
  logic                   acc;
  logic                   wr_acc;
  logic                   rd_stat;
  logic                   mapped;
  logic [31:0]            rd_nxt;
  logic [ACSW_EV_W-1:0]   ev_set;
  logic [ACSW_EV_W-1:0]   stat_nxt;
  logic [ACSW_EV_W-1:0]   gate;
  logic                   wdg_hit;

  // Setup cycle prepares the answer; access ends one cycle later
  assign setup   = psel && !penable;
  assign acc     = psel && penable && pready_r;
  assign wr_acc  = acc && pwrite;
  assign rd_stat = acc && !pwrite && paddr == ACSW_OFF_STAT;

  // Read mux, reserved bits read zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    mapped = 1'b1;
    unique case (paddr)
      ACSW_OFF_CTRL3: begin
        rd_nxt[ACSW_B_DONE_IEN] = done_ien_r;
        rd_nxt[ACSW_B_PDOWN]    = core_powered_down;
        rd_nxt[ACSW_B_RDY]      = core_ready;
        rd_nxt[ACSW_B_REF_RDY]  = int_reference_ready;
        rd_nxt[ACSW_B_REF_EN]   = ref_en_r;
      end
      ACSW_OFF_SAMP: rd_nxt[ACSW_CODE_W-1:0] = samp_code_r;
      ACSW_OFF_HIGH: rd_nxt[ACSW_LIM_W-1:0] = watch_high_limit_r;
      ACSW_OFF_LOW:  rd_nxt[ACSW_LIM_W-1:0] = watch_low_limit_r;
      ACSW_OFF_STAT: rd_nxt[ACSW_EV_W-1:0] = stat_r;
      ACSW_OFF_MASK: rd_nxt[ACSW_EV_W-1:0] = mask_r;
      default:       mapped = 1'b0;
    endcase
  end

  // Answer registers: ready, data and error for one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata_r <= rd_nxt;
      end
    end
  end

  // Control three writable fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_ien_r <= 1'b0;
      ref_en_r   <= 1'b0;
    end else if (wr_acc && paddr == ACSW_OFF_CTRL3) begin
      done_ien_r <= pwdata[ACSW_B_DONE_IEN];
      ref_en_r   <= pwdata[ACSW_B_REF_EN];
    end
  end

  // Sample time code; the timer latches it so edits mid-sample are harmless
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_code_r <= ACSW_SAMP_RST;
    end else if (wr_acc && paddr == ACSW_OFF_SAMP) begin
      samp_code_r <= pwdata[ACSW_CODE_W-1:0];
    end
  end

  // Watchdog limits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watch_high_limit_r <= ACSW_HIGH_RST;
      watch_low_limit_r  <= ACSW_LOW_RST;
    end else if (wr_acc) begin
      if (paddr == ACSW_OFF_HIGH) begin
        watch_high_limit_r <= pwdata[ACSW_LIM_W-1:0];
      end
      if (paddr == ACSW_OFF_LOW) begin
        watch_low_limit_r <= pwdata[ACSW_LIM_W-1:0];
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= ACSW_MASK_RST;
    end else if (wr_acc && paddr == ACSW_OFF_MASK) begin
      mask_r <= pwdata[ACSW_EV_W-1:0];
    end
  end

  // Watchdog compares the result as it completes
  assign wdg_hit = any_channel_done_flag &&
                   (conv_data > watch_high_limit_r ||
                    conv_data < watch_low_limit_r);

  always_comb begin
    ev_set               = '0;
    ev_set[ACSW_EV_DONE] = any_channel_done_flag;
    ev_set[ACSW_EV_WDG]  = wdg_hit;
  end

  // Sticky events: a read clears only the bits it returned, so an event
  // landing at the setup edge is not lost; a new event always wins
  assign stat_nxt = (stat_r & ~(rd_stat ? prdata_r[ACSW_EV_W-1:0] : '0)) | ev_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= '0;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // Done event also needs its control three enable
  always_comb begin
    gate               = mask_r;
    gate[ACSW_EV_DONE] = mask_r[ACSW_EV_DONE] && done_ien_r;
  end

  // Level interrupt from a flop; follows status one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(stat_r & gate);
    end
  end

  // Sampling phase timer
  acsw_sample_timer acsw_sample_timer_inst (
    .pclk          (pclk),
    .presetn       (presetn),
    .code          (samp_code_r),
    .start         (sample_start),
    .sampling_r    (sampling),
    .sample_done_r (sample_done)
  );

  // Outputs straight from flops
  assign pready               = pready_r;
  assign prdata               = prdata_r;
  assign pslverr              = pslverr_r;
  assign irq                  = irq_r;
  assign int_reference_enable = ref_en_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence apb_setup_s;
    psel && !penable;
  endsequence

  sequence apb_access_s(logic [7:0] off, logic dir);
    psel && penable && pready_r && paddr == off && pwrite == dir;
  endsequence

  apb_answer_a: assert property (apb_setup_s |=> pready_r ##1 !pready_r)
    else $error("apb answer not one access cycle");
  irq_done_a: assert property (stat_r[ACSW_EV_DONE] && done_ien_r
      && mask_r[ACSW_EV_DONE] |=> irq_r)
    else $error("done flag with enable gave no interrupt");
  irq_block_a: assert property (!done_ien_r && !(stat_r[ACSW_EV_WDG]
      && mask_r[ACSW_EV_WDG]) |=> !irq_r)
    else $error("interrupt with done enable cleared");
  pdown_read_a: assert property (apb_setup_s and paddr == ACSW_OFF_CTRL3 && !pwrite
      |=> prdata_r[ACSW_B_PDOWN] == $past(core_powered_down)
      && prdata_r[ACSW_B_RDY] == $past(core_ready))
    else $error("power state bits misread");
  ref_ready_a: assert property (apb_setup_s and paddr == ACSW_OFF_CTRL3 && !pwrite
      |=> prdata_r[ACSW_B_REF_RDY] == $past(int_reference_ready))
    else $error("reference ready bit misread");
  ref_enable_a: assert property (apb_access_s(ACSW_OFF_CTRL3, 1'b1)
      |=> int_reference_enable == $past(pwdata[ACSW_B_REF_EN]))
    else $error("reference enable not written");
  high_write_a: assert property (apb_access_s(ACSW_OFF_HIGH, 1'b1)
      |=> watch_high_limit_r == $past(pwdata[11:0]) ##1 $stable(watch_high_limit_r))
    else $error("high limit write lost");
  low_write_a: assert property (apb_access_s(ACSW_OFF_LOW, 1'b1)
      |=> watch_low_limit_r == $past(pwdata[11:0]))
    else $error("low limit write lost");
  watch_event_a: assert property (any_channel_done_flag
      && conv_data > watch_high_limit_r |=> stat_r[ACSW_EV_WDG])
    else $error("watchdog event missed");
  watch_quiet_a: assert property (!rd_stat && !stat_r[ACSW_EV_WDG] && !wdg_hit
      |=> !stat_r[ACSW_EV_WDG])
    else $error("spurious watchdog event");

endmodule : acsw_top

//--- sim/acsw_core_model.sv
// Behavioural conversion core facing the register block.
// Assumes the bench commands events, starts and power state on pclk.
module acsw_core_model
  import acsw_pkg::*;
(
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // Bench commands
  input  wire logic                  pd_req,
  input  wire logic                  ev_req,
  input  wire logic [ACSW_LIM_W-1:0] ev_data,
  input  wire logic                  st_req,
  input  wire logic                  int_reference_enable,
  // Core status
  output logic                       core_powered_down,
  output logic                       core_ready,
  output logic                       int_reference_ready,
  output logic                       any_channel_done_flag,
  output logic [ACSW_LIM_W-1:0]      conv_data,
  output logic                       sample_start
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] ref_cnt_r;

  // Buffer settles slowly after enable, drops at once without it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt_r <= 5'h0;
    end else if (!int_reference_enable) begin
      ref_cnt_r <= 5'h0;
    end else if (!ref_cnt_r[4]) begin
      ref_cnt_r <= ref_cnt_r + 5'h1;
    end
  end
  assign int_reference_ready = ref_cnt_r[4];

  // Result only valid with the done pulse, else a changing pattern
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      any_channel_done_flag <= 1'b0;
      conv_data             <= 12'h000;
      sample_start          <= 1'b0;
      core_powered_down     <= 1'b0;
      core_ready            <= 1'b0;
    end else begin
      any_channel_done_flag <= ev_req;
      conv_data             <= ev_req ? ev_data : ~conv_data;
      sample_start          <= st_req;
      core_powered_down     <= pd_req;
      core_ready            <= !pd_req;
    end
  end
endmodule : acsw_core_model

//--- sim/acsw_top_bench.sv
// Self-checking bench for the control three, sample time and limit block.
// Assumes the core model stands in for the converter on the same pclk.
module acsw_top_bench import acsw_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic w; logic [31:0] e; logic er;} acsw_note_s;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pd_req = 1'b0, ev_req = 1'b0, st_req = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [11:0] ev_data = 12'h000, conv_data, hi, lo;
  logic        pready, pslverr, core_powered_down, core_ready, int_reference_ready;
  logic        any_channel_done_flag, sample_start, int_reference_enable;
  logic        sampling, sample_done, irq;
  acsw_note_s  q[$], nt;
  int          fail_count = 0, samples_checked = 0, cyc = 0;

  always #10 pclk = ~pclk;

  acsw_top acsw_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .core_powered_down, .core_ready, .int_reference_ready,
    .any_channel_done_flag, .conv_data, .sample_start, .int_reference_enable, .sampling,
    .sample_done, .irq);
  acsw_core_model acsw_core_model_inst (.pclk, .presetn, .pd_req, .ev_req, .ev_data,
    .st_req, .int_reference_enable, .core_powered_down, .core_ready, .int_reference_ready,
    .any_channel_done_flag, .conv_data, .sample_start);

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t bit %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // For reads the data argument is the expected word; slave may stall
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic er);
    q.push_back('{w, d, er});
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Oldest note answers each completed transfer
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && q.size() > 0) begin
      nt = q.pop_front();
      if (!nt.w) chk_word(prdata, nt.e);
      chk_bit(pslverr, nt.er);
    end
  end

  // One conversion result, then irq level and read-clear of status
  task automatic ev(input logic [11:0] d, input logic [31:0] st, input logic ir);
    ev_req  <= 1'b1;
    ev_data <= d;
    @(posedge pclk);
    ev_req <= 1'b0;
    repeat (4) @(posedge pclk);
    chk_bit(irq, ir);
    apb(1'b0, ACSW_OFF_STAT, st, 1'b0);
    repeat (3) @(posedge pclk);
    chk_bit(irq, 1'b0);
  endtask : ev

  // Count sampling cycles and done pulses after one start
  task automatic samp(input logic [4:0] c, input logic [11:0] exp);
    int n;
    int k;
    n = 0;
    k = 0;
    apb(1'b1, ACSW_OFF_SAMP, {27'h0, c}, 1'b0);
    st_req <= 1'b1;
    @(posedge pclk);
    st_req <= 1'b0;
    repeat (int'(exp) + 20) begin
      @(posedge pclk);
      if (sampling === 1'b1) n++;
      if (sample_done === 1'b1) k++;
    end
    chk_word(n, {20'h0, exp});
    chk_word(k, {31'h0, exp != 12'h000});
  endtask : samp

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  // Hang guard well above the longest sample sweep
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    void'($urandom(31));
    hi = 12'($urandom_range(4000, 2000));
    lo = 12'($urandom_range(1000, 1));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ACSW_OFF_CTRL3, 32'h0000_0008, 1'b0);
    apb(1'b0, ACSW_OFF_SAMP, 32'h0000_0002, 1'b0);
    apb(1'b0, ACSW_OFF_HIGH, 32'h0000_0FFF, 1'b0);
    apb(1'b0, ACSW_OFF_LOW, 32'h0000_0000, 1'b0);
    apb(1'b0, ACSW_OFF_MASK, 32'h0000_0003, 1'b0);
    apb(1'b1, 8'h20, 32'hFFFF_FFFF, 1'b1);
    apb(1'b0, 8'h20, 32'h0000_0000, 1'b1);
    $display("reset test done");
    apb(1'b1, ACSW_OFF_CTRL3, 32'h0000_0002, 1'b0);
    apb(1'b0, ACSW_OFF_CTRL3, 32'h0000_000A, 1'b0);
    chk_bit(int_reference_enable, 1'b1);
    repeat (20) @(posedge pclk);
    apb(1'b0, ACSW_OFF_CTRL3, 32'h0000_000E, 1'b0);
    pd_req <= 1'b1;
    apb(1'b1, ACSW_OFF_CTRL3, 32'h0000_0020, 1'b0);
    repeat (4) @(posedge pclk);
    apb(1'b0, ACSW_OFF_CTRL3, 32'h0000_0030, 1'b0);
    pd_req <= 1'b0;
    $display("control test done");
    apb(1'b1, ACSW_OFF_HIGH, {20'h0, hi}, 1'b0);
    apb(1'b1, ACSW_OFF_LOW, {20'h0, lo}, 1'b0);
    apb(1'b0, ACSW_OFF_HIGH, {20'h0, hi}, 1'b0);
    apb(1'b0, ACSW_OFF_LOW, {20'h0, lo}, 1'b0);
    ev(hi, 32'h0000_0001, 1'b1);
    apb(1'b1, ACSW_OFF_CTRL3, 32'h0000_0000, 1'b0);
    ev(hi, 32'h0000_0001, 1'b0);
    ev(hi + 12'h001, 32'h0000_0003, 1'b1);
    ev(lo - 12'h001, 32'h0000_0003, 1'b1);
    ev(lo, 32'h0000_0001, 1'b0);
    apb(1'b1, ACSW_OFF_MASK, 32'h0000_0000, 1'b0);
    apb(1'b1, ACSW_OFF_CTRL3, 32'h0000_0020, 1'b0);
    ev(hi + 12'h001, 32'h0000_0003, 1'b0);
    $display("event test done");
    for (int i = 1; i < 18; i++) samp(5'(i), ACSW_SAMP_TAB[i]);
    samp(5'h00, 12'h000);
    samp(5'h12, 12'h000);
    $display("sample test done");
    final_report();
  end
endmodule : acsw_top_bench
